// ### core/boot_mode_select.sv
// reset-time selection of working or programming phase
`timescale 1ns/1ps
module boot_mode_select
	import boot_mode_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	input wire logic MODE_SEL_IN,
	input wire logic OPT_WR_IN,
	input wire logic [OPT_W-1:0] OPT_DATA_IN,
	input wire logic SDA_IN,
	input wire logic SCL_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT,
	output logic SCL_OUT,
	output logic SCL_OE_N_OUT,
	output logic PROG_MODE_OUT,
	output logic WORK_MODE_OUT,
	output logic I2C_ENABLE_OUT,
	output logic [CLK_SEL_W-1:0] CLK_SEL_OUT,
	output logic CPU_RUN_OUT,
	output logic [ADDR_W-1:0] FETCH_ADDR_OUT,
	output logic [OPT_W-1:0] OPT_VALUE_OUT,
	output logic OPT_WR_REJECT_OUT
);
	opt_if opt ();
	boot_state_t state;
	boot_state_t next_state;
	logic mode_meta;
	logic mode_sync;
	logic [CLK_SEL_W-1:0] clk_sel;
	logic [CLK_SEL_W-1:0] next_clk_sel;
	logic [ADDR_W-1:0] fetch_addr;
	logic [ADDR_W-1:0] next_fetch_addr;
	logic reject;
	logic next_reject;
	logic [7:0] settle;
	logic [7:0] next_settle;

	option_store u_store (
		.clk(CLK_IN),
		.rst(RESET_IN),
		.bus(opt.store)
	);

	// pin is asynchronous, two flops before anyone reads it
	always_ff @(posedge CLK_IN) begin
		mode_meta <= MODE_SEL_IN;
		mode_sync <= mode_meta;
	end

	// wait for the synchroniser to fill after release, then latch the mode once
	always_comb begin
		next_state = state;
		next_settle = settle;
		next_clk_sel = clk_sel;
		next_fetch_addr = fetch_addr;
		next_reject = 1'b0;
		unique case (state)
			ST_SAMPLE: begin
				next_clk_sel = CLK_INTERNAL;
				if (settle != 8'h00) begin
					next_settle = settle - 8'h01;
				end else if (mode_sync) begin
					next_state = ST_PROG;
				end else begin
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				next_clk_sel = opt.value[CLK_SEL_LSB +: CLK_SEL_W];
				next_fetch_addr = FETCH_START;
				next_state = ST_WORK;
			end
			ST_WORK: begin
				next_reject = OPT_WR_IN;
			end
			ST_PROG: begin
				next_clk_sel = CLK_INTERNAL;
			end
			default: next_state = ST_SAMPLE;
		endcase
		// only reset leaves a mode, later pin changes are ignored
		if (RESET_IN) begin
			next_state = ST_SAMPLE;
			next_settle = 8'(SETTLE_CYC);
			next_clk_sel = CLK_INTERNAL;
			next_fetch_addr = FETCH_START;
			next_reject = 1'b0;
		end
	end

	// plain register bank, every decision lives in the comb block above
	always_ff @(posedge CLK_IN) begin
		state <= next_state;
		settle <= next_settle;
		clk_sel <= next_clk_sel;
		fetch_addr <= next_fetch_addr;
		reject <= next_reject;
	end

	// the counter holds the decision back until the synchroniser has settled
	property p_settle_wait;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state == ST_SAMPLE) && (settle != 8'h00) |=> state == ST_SAMPLE;
	endproperty
	a_settle_wait: assert property (p_settle_wait)
		else $error("mode chosen before the pin settled");

	// the decision follows the synchronised pin level at the zero count
	property p_decide;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state == ST_SAMPLE) && (settle == 8'h00) |=> PROG_MODE_OUT == $past(mode_sync);
	endproperty
	a_decide: assert property (p_decide)
		else $error("mode does not follow the pin");

	// a held reset always parks the selector with no phase active
	property p_reset_idle;
		@(posedge CLK_IN)
		RESET_IN |=> !PROG_MODE_OUT && !WORK_MODE_OUT;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("phase active after reset");

	// boot always starts on the internal oscillator
	property p_boot_clk;
		@(posedge CLK_IN)
		$fell(RESET_IN) |-> CLK_SEL_OUT == CLK_INTERNAL;
	endproperty
	a_boot_clk: assert property (p_boot_clk)
		else $error("boot not on internal oscillator");

	// the stored clock mode reaches the clock switch right after the load step
	property p_load_clk;
		@(posedge CLK_IN) disable iff (RESET_IN)
		state == ST_LOAD |=> CLK_SEL_OUT == $past(opt.value[CLK_SEL_LSB +: CLK_SEL_W]);
	endproperty
	a_load_clk: assert property (p_load_clk)
		else $error("clock mode not applied");

	// the load step hands over to the running core at the first location
	property p_load_run;
		@(posedge CLK_IN) disable iff (RESET_IN)
		state == ST_LOAD |=> WORK_MODE_OUT && CPU_RUN_OUT && FETCH_ADDR_OUT == FETCH_START;
	endproperty
	a_load_run: assert property (p_load_run)
		else $error("core not started after load");

	// running code has no path to move the clock source
	property p_work_clk;
		@(posedge CLK_IN) disable iff (RESET_IN)
		WORK_MODE_OUT |=> $stable(CLK_SEL_OUT);
	endproperty
	a_work_clk: assert property (p_work_clk)
		else $error("clock source moved while working");

	// one decode for the option write gate and every phase output
	function automatic logic in_phase(input boot_state_t now, input boot_state_t want);
		return now == want;
	endfunction : in_phase

	// option byte port opens only in programming phase
	assign opt.wr_en = in_phase(state, ST_PROG) && OPT_WR_IN;
	assign opt.wr_data = OPT_DATA_IN;
	assign OPT_VALUE_OUT = opt.value;
	assign OPT_WR_REJECT_OUT = reject;

	// the store gate must stay shut outside the programming phase
	property p_opt_lock;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state != ST_PROG) |-> !opt.wr_en;
	endproperty
	a_opt_lock: assert property (p_opt_lock)
		else $error("option write outside programming");

	// a strobe in programming phase lands in the store on the next edge
	property p_opt_take;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state == ST_PROG) && OPT_WR_IN |=> opt.value == $past(OPT_DATA_IN);
	endproperty
	a_opt_take: assert property (p_opt_take)
		else $error("option write lost");

	// software sees its refused write as a one-cycle flag
	property p_reject;
		@(posedge CLK_IN) disable iff (RESET_IN)
		WORK_MODE_OUT && OPT_WR_IN |=> OPT_WR_REJECT_OUT;
	endproperty
	a_reject: assert property (p_reject)
		else $error("rejected write not flagged");

	// device never drives the I2C lines here; the peripheral owns them
	assign SDA_OUT = 1'b0;
	assign SCL_OUT = 1'b0;
	assign SDA_OE_N_OUT = 1'b1;
	assign SCL_OE_N_OUT = 1'b1;

	// phase outputs decode the one-hot state register, so they cannot glitch
	assign PROG_MODE_OUT = in_phase(state, ST_PROG);
	assign WORK_MODE_OUT = in_phase(state, ST_WORK);
	assign I2C_ENABLE_OUT = in_phase(state, ST_PROG);
	assign CLK_SEL_OUT = clk_sel;
	assign CPU_RUN_OUT = in_phase(state, ST_WORK);
	assign FETCH_ADDR_OUT = fetch_addr;

	// option clock modes are ignored while programming
	property p_prog_clk;
		@(posedge CLK_IN) disable iff (RESET_IN)
		PROG_MODE_OUT |-> CLK_SEL_OUT == CLK_INTERNAL;
	endproperty
	a_prog_clk: assert property (p_prog_clk)
		else $error("programming not on internal oscillator");

	// the core is pointed at the first location as it starts
	property p_fetch;
		@(posedge CLK_IN) disable iff (RESET_IN)
		$rose(WORK_MODE_OUT) |-> FETCH_ADDR_OUT == FETCH_START;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch not at first location");

	// once chosen, a phase only ends through reset
	property p_hold;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(PROG_MODE_OUT || WORK_MODE_OUT) |=> $stable(PROG_MODE_OUT) && $stable(WORK_MODE_OUT);
	endproperty
	a_hold: assert property (p_hold)
		else $error("mode changed without reset");

	// the two phases never overlap
	property p_excl;
		@(posedge CLK_IN) disable iff (RESET_IN)
		!(PROG_MODE_OUT && WORK_MODE_OUT);
	endproperty
	a_excl: assert property (p_excl)
		else $error("both phases active");

	// the I2C peripheral is enabled exactly in programming phase, lines released
	property p_i2c;
		@(posedge CLK_IN) disable iff (RESET_IN)
		I2C_ENABLE_OUT == PROG_MODE_OUT && SDA_OE_N_OUT && SCL_OE_N_OUT;
	endproperty
	a_i2c: assert property (p_i2c)
		else $error("i2c ownership wrong");
endmodule : boot_mode_select

// ### core/boot_mode_pkg.sv
// constants and types for the boot mode selector
// Function
// - mode changes only through a reset applied after the pin changes
// - option byte writes accepted only in programming mode
// - programming exchange runs over the on-chip I2C peripheral lines
// - programming mode always clocks from the internal oscillator
// - after reset run internal oscillator, then switch to option byte clock mode; the switch happens in working mode only
// - working mode starts fetching at the first memory location
package boot_mode_pkg;
	localparam int OPT_W = 8;
	localparam int CLK_SEL_W = 2;
	localparam int CLK_SEL_LSB = 0;
	localparam int ADDR_W = 13;
	localparam logic [ADDR_W-1:0] FETCH_START = 13'h0000;
	localparam logic [OPT_W-1:0] OPT_RESET = 8'h00;
	localparam logic [CLK_SEL_W-1:0] CLK_INTERNAL = 2'h0;
	localparam int SETTLE_NS = 1000;
	localparam int CLK_NS = 25;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [3:0] {
		ST_SAMPLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_WORK = 4'h4,
		ST_PROG = 4'h8
	} boot_state_t;
endpackage : boot_mode_pkg

// ### core/opt_if.sv
// option byte store carrier between selector and store
`timescale 1ns/1ps
interface opt_if;
	import boot_mode_pkg::*;
	logic wr_en;
	logic [OPT_W-1:0] wr_data;
	logic [OPT_W-1:0] value;
	modport ctrl (output wr_en, output wr_data, input value);
	modport store (input wr_en, input wr_data, output value);
endinterface : opt_if

// ### core/option_store.sv
// option byte holding register
`timescale 1ns/1ps
module option_store
	import boot_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	opt_if.store bus
);
	logic [OPT_W-1:0] value;
	logic [OPT_W-1:0] next_value;

	// writes only arrive while the selector allows them; none are taken under reset
	always_comb begin
		next_value = value;
		if (bus.wr_en && !rst) begin
			next_value = bus.wr_data;
		end
	end

	// stands in for nonvolatile cells, so it keeps its value through reset
	always_ff @(posedge clk) begin
		value <= next_value;
	end

	assign bus.value = value;
endmodule : option_store

// ### bench/prog_tool.sv
// programming tool model: option strobe and pulled-up i2c lines
`timescale 1ns/1ps
module prog_tool
	import boot_mode_pkg::*;
(
	input wire logic clk_in,
	input wire logic send_in,
	input wire logic [OPT_W-1:0] byte_in,
	input wire logic sda_oe_n_in,
	input wire logic sda_in,
	input wire logic scl_oe_n_in,
	input wire logic scl_in,
	output logic wr_out,
	output logic [OPT_W-1:0] data_out,
	output logic sda_out,
	output logic scl_out
);
	// data is inverted off the strobe so stale bytes never look valid
	always_ff @(posedge clk_in) begin
		wr_out <= send_in;
		data_out <= send_in ? byte_in : ~data_out;
	end
	// open-drain wires with pull-ups
	assign sda_out = (!sda_oe_n_in && !sda_in) ? 1'b0 : 1'b1;
	assign scl_out = (!scl_oe_n_in && !scl_in) ? 1'b0 : 1'b1;
endmodule : prog_tool

// ### bench/testbench.sv
// boot mode selector bench with option byte model
`timescale 1ns/1ps
module testbench;
	import boot_mode_pkg::*;
	logic clk = 0, rst = 1, mode = 0, send = 0, wr, sda, scl, sdo, sdoe, sco, scoe;
	logic prog, work, i2c, run, rej;
	logic [7:0] byte_v = 8'h00, data, opt;
	logic [1:0] sel;
	logic [12:0] fetch;
	integer seed = 32'hee3f;
	int failures = 0, n_tests = 0, cycles = 0, opt_m = 0;
	int sel_q[$];
	always #12.5 clk = ~clk;
	prog_tool tool_u (.clk_in(clk), .send_in(send), .byte_in(byte_v), .sda_oe_n_in(sdoe),
		.sda_in(sdo), .scl_oe_n_in(scoe), .scl_in(sco), .wr_out(wr), .data_out(data),
		.sda_out(sda), .scl_out(scl));
	boot_mode_select dut_u (.CLK_IN(clk), .RESET_IN(rst), .MODE_SEL_IN(mode), .OPT_WR_IN(wr),
		.OPT_DATA_IN(data), .SDA_IN(sda), .SCL_IN(scl), .SDA_OUT(sdo), .SDA_OE_N_OUT(sdoe),
		.SCL_OUT(sco), .SCL_OE_N_OUT(scoe), .PROG_MODE_OUT(prog), .WORK_MODE_OUT(work),
		.I2C_ENABLE_OUT(i2c), .CLK_SEL_OUT(sel), .CPU_RUN_OUT(run), .FETCH_ADDR_OUT(fetch),
		.OPT_VALUE_OUT(opt), .OPT_WR_REJECT_OUT(rej));
	task tally_and_finish;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// reset with pin level m, then flip the pin; the mode must hold
	task boot(input logic m);
		tick(1);
		rst <= 1;
		mode <= m;
		tick(12);
		rst <= 0;
		tick(5);
		#1 check("early sel", sel, CLK_INTERNAL);
		check("early mode", {prog, work, run, i2c}, 4'h0);
		tick(40);
		mode <= !m;
		tick(3);
		#1 check("prog", prog, m);
		check("work", work, !m);
		check("i2c", i2c, m);
		check("run", run, !m);
		check("lines", {sdo, sco, sdoe, scoe, sda, scl}, 6'h0F);
	endtask : boot
	task wr_opt(input logic [7:0] v, input logic in_prog);
		tick(1);
		send <= 1;
		byte_v <= v;
		tick(1);
		send <= 0;
		tick(1);
		if (in_prog) opt_m = v;
		#1 check("reject", rej, !in_prog);
		check("opt", opt, opt_m[7:0]);
	endtask : wr_opt
	// every clock mode: programmed in one phase, applied in the next
	initial begin
		for (int i = 0; i < 4; i++) begin
			boot(1);
			check("prog sel", sel, CLK_INTERNAL);
			byte_v = 8'($random(seed));
			wr_opt(~byte_v, 1);
			wr_opt({byte_v[7:2], i[1:0]}, 1);
			sel_q.push_back(i);
			boot(0);
			check("sel", sel, sel_q.pop_front());
			check("fetch", fetch, FETCH_START);
			wr_opt(~opt_m[7:0], 0);
			check("sel kept", sel, i);
			$display("test %0d done", i);
		end
		tally_and_finish();
	end
endmodule : testbench
